/* File: sdac_loader.v */
// Behaviour
// RULE_01 - D8..D11 select channel, D8 most significant
// RULE_02 - Selectors zero and seven up load nothing
// RULE_03 - D0..D7 code, D7 most significant
// RULE_04 - Output level is code plus one steps
// RULE_05 - Load acts regardless of serial clock level
// RULE_06 - Power-on reset clears internal state
// RULE_07 - Rising clock shifts; load copies code to latch
`timescale 1ns/1ns
`default_nettype none
`include "sdac_regs.vh"

// ****************************************************************
// Serial six-channel converter loader
// ****************************************************************
module sdac_loader #(
    parameter NUM_CH = `SDAC_NUM_CH,
    parameter POR_CYCLES = (`SDAC_CLK_HZ / 1000) * `SDAC_POR_MS
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire serial_clk_i,
    input wire serial_data_in_i,
    input wire load_strobe_i,
    output reg serial_data_out_o,
    output reg por_busy_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_1_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_2_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_3_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_4_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_5_o,
    output reg [`SDAC_LEVEL_W-1:0] analog_out_6_o
);
    // Limitations of this front end:
    // - the link pins are sampled by the system clock, so each high
    //   and low phase of the link clock must span three system clocks
    // - data must hold steady across that same sampling window
    // - a strobe held high reloads the latch on every cycle, so the
    //   host must not clock new bits while the strobe stands high
    // - the outputs are digital levels; the analogue stage is outside
    // One-hot states of the power-on sequencer
    localparam [1:0] ST_INIT = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    wire [2:0] pins_s;
    wire sck_s;
    wire din_s;
    wire load_s;
    reg sck_prev_q;
    reg [`SDAC_WORD_W-1:0] shift_q;
    reg [`SDAC_WORD_W-1:0] shift_d;
    reg [`SDAC_CODE_W-1:0] latch_q [0:5];
    reg [1:0] state_q;
    reg [31:0] por_cnt_q;
    wire sck_rise;
    wire [`SDAC_SEL_W-1:0] sel_w;
    wire [5:0] ch_hit;
    integer i;

    // Level for a stored code: (n + 1) steps of span / 256
    function [`SDAC_LEVEL_W-1:0] sdac_level;
        input [`SDAC_CODE_W-1:0] code;
        begin
            sdac_level = {1'b0, code} + 9'h001; // RULE_04
        end
    endfunction

    // True when selector addresses a real channel
    function sdac_sel_ok;
        input [`SDAC_SEL_W-1:0] sel;
        begin
            sdac_sel_ok = (sel >= `SDAC_SEL_FIRST) &&
                (sel <= `SDAC_SEL_LAST); // RULE_02
        end
    endfunction

    // One-hot latch enable for selector values 1..6
    function [5:0] sdac_chan_dec;
        input [`SDAC_SEL_W-1:0] sel;
        integer k;
        begin
            sdac_chan_dec = 6'h00;
            for (k = 0; k < 6; k = k + 1) begin
                if (sel == k[3:0] + 4'h1) begin
                    sdac_chan_dec[k] = 1'b1;
                end
            end
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    sdac_sync #(
        .W(3)
    ) u_sdac_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({serial_clk_i, serial_data_in_i, load_strobe_i}),
        .sync_o(pins_s)
    );

    // Same two flop stages carry all three pins, so data and strobe keep
    // their place relative to the clock edge that qualifies them
    assign sck_s = pins_s[2];
    assign din_s = pins_s[1];
    assign load_s = pins_s[0];
    assign sck_rise = sck_s & ~sck_prev_q;

    // Word arrives D11 first, so after twelve shifts word bit k holds
    // Dk; the selector reads back to front, with D8 as its top bit
    assign sel_w = {shift_q[`SDAC_SEL_LSB], shift_q[9], shift_q[10],
        shift_q[`SDAC_SEL_MSB]}; // RULE_01

    // Latch enables; unused selector values enable nothing
    assign ch_hit = sdac_sel_ok(sel_w) ? sdac_chan_dec(sel_w) :
        6'h00; // RULE_02

    // ****************************************************************
    // Power-on sequencer
    // ****************************************************************
    // Holds the link quiet for the restart interval after reset
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_INIT;
            por_cnt_q <= 32'h0;
            por_busy_o <= 1'b1;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (por_cnt_q >= POR_CYCLES - 1) begin
                        state_q <= ST_RUN;
                        por_busy_o <= 1'b0;
                    end else begin
                        por_cnt_q <= por_cnt_q + 32'h1; // RULE_06
                    end
                end
                ST_RUN: begin
                    por_busy_o <= 1'b0;
                end
                default: begin
                    state_q <= ST_INIT;
                    por_busy_o <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Shift register
    // ****************************************************************
    // Word arrives D11 first; new top bit after each shift goes to data out
    // The shift register is held at zero while the sequencer holds the link quiet
    always @* begin
        shift_d = shift_q;
        if (sck_rise) begin
            shift_d = {shift_q[`SDAC_WORD_W-2:0], din_s}; // RULE_07
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_prev_q <= 1'b0;
            shift_q <= {`SDAC_WORD_W{1'b0}};
            serial_data_out_o <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            if (state_q == ST_RUN) begin
                shift_q <= shift_d;
                serial_data_out_o <= shift_d[`SDAC_WORD_W-1]; // RULE_07
            end else begin
                shift_q <= {`SDAC_WORD_W{1'b0}}; // RULE_06
                serial_data_out_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Channel latches
    // ****************************************************************
    // Level sensitive load: clock level is never looked at, so a
    // strobe held high keeps copying the current word
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < 6; i = i + 1) begin
                latch_q[i] <= `SDAC_CODE_RST;
            end
        end else if (state_q == ST_RUN && load_s) begin // RULE_05
            for (i = 0; i < 6; i = i + 1) begin
                if (ch_hit[i]) begin
                    // Code D7..D0 in word bits 7..0
                    latch_q[i] <= shift_q[`SDAC_CODE_MSB:
                        `SDAC_CODE_LSB]; // RULE_03
                end
            end
        end
    end

    // ****************************************************************
    // Output levels
    // ****************************************************************
    // One cycle behind the latches; a load shows four clocks after
    // the strobe pin rises, and every output comes from a flop
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_out_1_o <= `SDAC_LEVEL_RST;
            analog_out_2_o <= `SDAC_LEVEL_RST;
            analog_out_3_o <= `SDAC_LEVEL_RST;
            analog_out_4_o <= `SDAC_LEVEL_RST;
            analog_out_5_o <= `SDAC_LEVEL_RST;
            analog_out_6_o <= `SDAC_LEVEL_RST;
        end else begin
            analog_out_1_o <= sdac_level(latch_q[0]); // RULE_04
            analog_out_2_o <= sdac_level(latch_q[1]);
            analog_out_3_o <= sdac_level(latch_q[2]);
            analog_out_4_o <= sdac_level(latch_q[3]);
            analog_out_5_o <= sdac_level(latch_q[4]);
            analog_out_6_o <= sdac_level(latch_q[5]);
        end
    end
endmodule // sdac_loader

`default_nettype wire

/* File: sdac_regs.vh */
`ifndef SDAC_REGS_VH
`define SDAC_REGS_VH

// ****************************************************************
// Word layout
// ****************************************************************
`define SDAC_WORD_W 12
`define SDAC_CODE_LSB 0
`define SDAC_CODE_MSB 7
`define SDAC_SEL_LSB 8
`define SDAC_SEL_MSB 11
`define SDAC_CODE_W 8
`define SDAC_SEL_W 4
`define SDAC_NUM_CH 6
`define SDAC_CODE_RST 8'h00
`define SDAC_SEL_NONE 4'h0
`define SDAC_SEL_FIRST 4'h1
`define SDAC_SEL_LAST 4'h6

// ****************************************************************
// Output level scale
// ****************************************************************
`define SDAC_LEVEL_W 9
`define SDAC_STEPS 256
`define SDAC_LEVEL_RST 9'h001

// ****************************************************************
// Power-on reset
// ****************************************************************
`define SDAC_POR_MS 1
`define SDAC_CLK_HZ 25000000

`endif

/* File: sdac_sync.v */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for asynchronous pins
// ****************************************************************
module sdac_sync #(
    parameter W = 3
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta_q;

    // First stage read only by second stage
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // sdac_sync

`default_nettype wire

/* File: sdac_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ************
// Host side of the three-wire link
// ************
module sdac_host (
    input wire logic clk_i,
    output logic sclk_o,
    output logic sdi_o,
    output logic load_o
);
    // Link idle: clock low, strobe low
    initial begin
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        load_o = 1'b0;
    end
    // Shift a word out, D11 first; hi leaves clock high after bit D0
    task automatic send(input logic [11:0] w, input int h, input bit hi);
        for (int i = 11; i >= 0; i--) begin
            sdi_o <= w[i];
            repeat (h) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (h) @(posedge clk_i);
            if (i > 0 || !hi) sclk_o <= 1'b0;
        end
        sdi_o <= ~w[0]; // Released line must not look stable
    endtask
    // Strobe, then drop clock and let outputs settle
    task automatic load(input int n);
        load_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        load_o <= 1'b0;
        sclk_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // sdac_host
`default_nettype wire

/* File: sdac_loader_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ************
// Port checker
// ************
module sdac_chk #(parameter POR_CYCLES = 20) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_in_i,
    input wire logic load_strobe_i,
    input wire logic serial_data_out_o,
    input wire logic por_busy_o,
    input wire logic [8:0] analog_out_1_o,
    input wire logic [8:0] analog_out_2_o,
    input wire logic [8:0] analog_out_3_o,
    input wire logic [8:0] analog_out_4_o,
    input wire logic [8:0] analog_out_5_o,
    input wire logic [8:0] analog_out_6_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] age_q;
    // Cycles since reset release, saturating so it never wraps
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) age_q <= 16'h0000;
        else if (age_q != 16'hffff) age_q <= age_q + 16'h0001;
    end
    chk_por_held: assert property (
        age_q < POR_CYCLES - 1 |-> por_busy_o)
        else $error("busy dropped early");
    chk_por_done: assert property (
        age_q > POR_CYCLES + 1 |-> !por_busy_o)
        else $error("busy stuck");
    chk_por_quiet: assert property (por_busy_o |->
        !serial_data_out_o && analog_out_1_o == 9'h001)
        else $error("activity while busy");
    chk_lvl_range: assert property (analog_out_3_o != 9'h000
        && analog_out_3_o <= 9'h100) else $error("level out of range");
    chk_sdo_rise: assert property ($changed(serial_data_out_o) |->
        $past(serial_clk_i) && !$past(serial_clk_i, 5)) else $error("no rise");
    chk_load_cause: assert property ($changed(analog_out_2_o) |->
        $past(load_strobe_i, 3) || $past(load_strobe_i, 4)
        || $past(load_strobe_i, 5)) else $error("change without load");
    chk_one_chan: assert property ($onehot0({
        $changed(analog_out_1_o), $changed(analog_out_2_o),
        $changed(analog_out_3_o), $changed(analog_out_4_o),
        $changed(analog_out_5_o), $changed(analog_out_6_o)}))
        else $error("two channels moved");
    chk_out_stands: assert property (!load_strobe_i [*6] |=>
        $stable(analog_out_1_o)) else $error("output drifted");
    cover property ($changed(analog_out_6_o));
    cover property ($changed(serial_data_out_o));
    cover property (load_strobe_i && serial_clk_i);
endmodule // sdac_chk
bind sdac_loader sdac_chk #(.POR_CYCLES(POR_CYCLES)) u_sdac_chk (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .serial_clk_i(serial_clk_i),
    .serial_data_in_i(serial_data_in_i),
    .load_strobe_i(load_strobe_i),
    .serial_data_out_o(serial_data_out_o),
    .por_busy_o(por_busy_o),
    .analog_out_1_o(analog_out_1_o),
    .analog_out_2_o(analog_out_2_o),
    .analog_out_3_o(analog_out_3_o),
    .analog_out_4_o(analog_out_4_o),
    .analog_out_5_o(analog_out_5_o),
    .analog_out_6_o(analog_out_6_o)
);
`default_nettype wire

/* File: sdac_loader_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ************
// Loader testbench
// ************
module sdac_loader_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wire sclk, sdi, load, sdo, busy;
    wire [8:0] ao [1:6];
    logic [8:0] exp_q [1:6];
    logic [7:0] codes [1:6] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h5a, 8'ha5};
    int err_count = 0;
    int tests_run = 0;
    // 25 MHz clock
    always #20 sys_clk_i = ~sys_clk_i;
    sdac_host u_sdac_host (.clk_i(sys_clk_i), .sclk_o(sclk), .sdi_o(sdi),
        .load_o(load));
    // Short restart interval keeps the run brief
    sdac_loader #(.POR_CYCLES(20)) u_sdac_loader (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .serial_clk_i(sclk), .serial_data_in_i(sdi),
        .load_strobe_i(load), .serial_data_out_o(sdo), .por_busy_o(busy),
        .analog_out_1_o(ao[1]), .analog_out_2_o(ao[2]),
        .analog_out_3_o(ao[3]), .analog_out_4_o(ao[4]),
        .analog_out_5_o(ao[5]), .analog_out_6_o(ao[6]));
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic chk_all;
        for (int c = 1; c <= 6; c++) check(ao[c], exp_q[c]);
    endtask
    // Reset, check cleared outputs, wait out the restart interval
    task automatic do_reset;
        rst_n_i <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        for (int c = 1; c <= 6; c++) exp_q[c] = 9'h001;
        check({8'h00, busy}, 9'h001);
        chk_all();
        rst_n_i <= 1'b1;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk_i);
        check({8'h00, busy}, 9'h000);
        $display("reset done");
    endtask
    // One frame: selector bit 0 goes out first as D11, D8 last
    task automatic put(input logic [3:0] s, input logic [7:0] c, input int h,
            input bit hi);
        u_sdac_host.send({s[0], s[1], s[2], s[3], c}, h, hi);
        u_sdac_host.load(4);
        if (s >= 4'h1 && s <= 4'h6) exp_q[s] = c + 9'h001;
        check({8'h00, sdo}, {8'h00, s[0]});
        chk_all();
    endtask
    // Every real channel takes its own code
    task automatic test_all_channels;
        for (int c = 1; c <= 6; c++) begin
            put(c[3:0], codes[c], 4, 1'b0);
        end
        $display("test_all_channels done");
    endtask
    // Unused selectors leave every output alone
    task automatic test_bad_selectors;
        for (int s = 0; s < 16; s++) begin
            if (s < 1 || s > 6) begin
                put(s[3:0], 8'h3c, 4, 1'b0);
            end
        end
        $display("test_bad_selectors done");
    endtask
    // Load taken while the link clock rests high
    task automatic test_load_clk_high;
        put(4'h3, 8'h7e, 4, 1'b1);
        $display("test_load_clk_high done");
    endtask
    // Reset in mid-run clears the latches, then a fresh load
    task automatic test_mid_reset;
        do_reset();
        put(4'h6, 8'hc3, 4, 1'b0);
        $display("test_mid_reset done");
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset();
        test_all_channels();
        test_bad_selectors();
        test_load_clk_high();
        test_mid_reset();
        results();
    end
    // Watchdog, well past the expected run length
    initial begin
        #400000;
        err_count++;
        results();
    end
endmodule // sdac_loader_tb
`default_nettype wire
